/* hw/scsh_top.v */
/*
 * pin-level control, status and host port steering of a network clock
 * synchroniser: mode strap/pin, lock and holdover outputs, open-drain
 * interrupt, spi/i2c pin sharing, telecom frame pulse default rate.
 * assumes reset comes from the device reset pin already inverted and held
 * by the board; the serial protocol engines sit on the core side ports.
 */
// Operation
// - during reset the mode pin level picks the default mode, low normal, high free-run.
// - after reset the mode follows the pin or the mode select register at 0x1F.
// - the phase aligned output is high while the loop is frequency and phase locked.
// - the coasting output is high while the loop is in holdover.
// - a high port select strap enables the i2c port, a low one the spi port.
// - the shared clock pin is the spi clock input or the bidirectional i2c clock.
// - the shared data pin is the spi data input or the bidirectional i2c data line.
// - the serial output pin carries spi read data and is unused in i2c mode.
// - the select pin is spi chip select, active low, or i2c address bit 0.
// - the interrupt pin is pulled low on a status change and the host reads the status regs.
// - the frame pulse style is configurable and defaults to 8 kHz after reset.
`timescale 1ns/10ps
`default_nettype none
`include "scsh_defines.vh"

module scsh_top #(
  parameter FP_DIV_W = 16,
  parameter FP_DIV   = `SCSH_FP_DEF_DIV
) (
  input  wire                mclk,
  input  wire                reset,
  // pins
  input  wire                mode_pin,
  input  wire                i2c_sel_pin,
  input  wire                serial_clk_in,
  output reg                 serial_clk_oe_n,
  input  wire                serial_data_in,
  output reg                 serial_data_oe_n,
  output reg                 serial_out,
  input  wire                select_or_addr_bit0_pin,
  output reg                 int_oe_n,
  output reg                 lock_out,
  output reg                 hold_out,
  output reg                 telecom_frame_pulse_out,
  // core side
  input  wire                loop_locked,
  input  wire                loop_holdover,
  input  wire                status_change,
  input  wire                irq_pending,
  input  wire                reg_wr,
  input  wire [7:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                spi_so_data,
  input  wire                i2c_scl_low,
  input  wire                i2c_sda_low,
  input  wire                fp_cfg_wr,
  input  wire [FP_DIV_W-1:0] fp_cfg_div,
  input  wire [FP_DIV_W-1:0] fp_cfg_width,
  input  wire                fp_cfg_inv,
  output reg                 mode_freerun,
  output reg                 i2c_enabled,
  output reg                 spi_enabled,
  output reg                 host_clk,
  output reg                 host_data,
  output reg                 spi_cs_n,
  output reg                 i2c_addr_bit0
);

  wire mode_s;
  wire i2c_s;
  wire sclk_s;
  wire sdat_s;
  wire sel_s;

  // =====================================================================
  // pin synchronisers
  scsh_sync2 #(.RST_VAL(1'b1)) u_mode (.clk(mclk), .reset(1'b0),
    .d(mode_pin), .q(mode_s));
  scsh_sync2 #(.RST_VAL(1'b1)) u_i2c  (.clk(mclk), .reset(1'b0),
    .d(i2c_sel_pin), .q(i2c_s));
  scsh_sync2 #(.RST_VAL(1'b1)) u_sclk (.clk(mclk), .reset(1'b0),
    .d(serial_clk_in), .q(sclk_s));
  scsh_sync2 #(.RST_VAL(1'b1)) u_sdat (.clk(mclk), .reset(1'b0),
    .d(serial_data_in), .q(sdat_s));
  scsh_sync2 #(.RST_VAL(1'b1)) u_sel  (.clk(mclk), .reset(1'b0),
    .d(select_or_addr_bit0_pin), .q(sel_s));

  // =====================================================================
  // mode control
  // synchronisers run through reset so the strap is valid while it is held
  reg mode_reg_q;
  // no source flag is kept: the later of a write and a pin edge rules
  reg mode_pin_last_q;
  reg mode_d;

  always @(posedge mclk) begin
    if (reset) begin
      mode_reg_q      <= mode_s;
      mode_pin_last_q <= mode_s;
    end else begin
      mode_pin_last_q <= mode_s;
      if (reg_wr && reg_addr == `SCSH_MODE_REG_ADDR) begin
        // a write in the same cycle as a pin edge wins
        mode_reg_q     <= reg_wdata[`SCSH_MODE_BIT];
      end else if (mode_s != mode_pin_last_q) begin
        // a fresh pin edge takes control back from the register
        mode_reg_q     <= mode_s;
      end
    end
  end

  always @* begin
    mode_d = mode_reg_q;
  end

  // =====================================================================
  // status, port steering and pins
  always @(posedge mclk) begin
    if (reset) begin
      mode_freerun     <= `SCSH_MODE_NORMAL;
      lock_out         <= 1'b0;
      hold_out         <= 1'b0;
      int_oe_n         <= 1'b1;
      i2c_enabled      <= 1'b0;
      spi_enabled      <= 1'b0;
      serial_clk_oe_n  <= 1'b1;
      serial_data_oe_n <= 1'b1;
      serial_out       <= 1'b0;
      host_clk         <= 1'b1;
      host_data        <= 1'b1;
      spi_cs_n         <= 1'b1;
      i2c_addr_bit0    <= 1'b0;
    end else begin
      mode_freerun <= mode_d;
      lock_out     <= loop_locked;
      hold_out     <= loop_holdover;
      // held low from a status change until the host clears the pending state
      int_oe_n     <= ~(irq_pending | status_change);
      i2c_enabled  <= (i2c_s == `SCSH_PORT_I2C);
      spi_enabled  <= (i2c_s == `SCSH_PORT_SPI);
      host_clk     <= sclk_s;
      host_data    <= sdat_s;
      if (i2c_s == `SCSH_PORT_I2C) begin
        serial_clk_oe_n  <= ~i2c_scl_low;
        serial_data_oe_n <= ~i2c_sda_low;
        serial_out       <= 1'b0;
        spi_cs_n         <= 1'b1;
        i2c_addr_bit0    <= sel_s;
      end else begin
        serial_clk_oe_n  <= 1'b1;
        serial_data_oe_n <= 1'b1;
        serial_out       <= spi_so_data;
        spi_cs_n         <= sel_s;
        i2c_addr_bit0    <= 1'b0;
      end
    end
  end

  // =====================================================================
  // telecom frame pulse generator
  // a shorter period written mid-count wraps at once through the >= compare
  // a width at or above the period gives a constant level
  reg [FP_DIV_W-1:0] fp_div_q;
  reg [FP_DIV_W-1:0] fp_width_q;
  reg                fp_inv_q;
  reg [FP_DIV_W-1:0] fp_cnt_q;

  always @(posedge mclk) begin
    if (reset) begin
      fp_div_q   <= FP_DIV[FP_DIV_W-1:0];
      fp_width_q <= {{(FP_DIV_W-1){1'b0}}, 1'b1};
      fp_inv_q   <= 1'b0;
      fp_cnt_q   <= {FP_DIV_W{1'b0}};
      telecom_frame_pulse_out <= 1'b0;
    end else begin
      if (fp_cfg_wr) begin
        fp_div_q   <= fp_cfg_div;
        fp_width_q <= fp_cfg_width;
        fp_inv_q   <= fp_cfg_inv;
      end
      if (fp_cnt_q >= fp_div_q - {{(FP_DIV_W-1){1'b0}}, 1'b1})
        fp_cnt_q <= {FP_DIV_W{1'b0}};
      else
        fp_cnt_q <= fp_cnt_q + {{(FP_DIV_W-1){1'b0}}, 1'b1};
      telecom_frame_pulse_out <= (fp_cnt_q < fp_width_q) ^ fp_inv_q;
    end
  end

endmodule

`default_nettype wire

/* include/scsh_defines.vh */
/*
 * constants for the sync control/status/host pin block: mode codes,
 * strap values, timing figures and frame pulse default.
 * assumes a 100 MHz core clock (mclk).
 */
`ifndef SCSH_DEFINES_VH
`define SCSH_DEFINES_VH

// =====================================================================
// mode encoding
`define SCSH_MODE_NORMAL     1'b0
`define SCSH_MODE_FREERUN    1'b1
`define SCSH_MODE_REG_ADDR   8'h1F
`define SCSH_MODE_BIT        0
`define SCSH_MODE_SRC_BIT    1

// =====================================================================
// port select strap
`define SCSH_PORT_SPI        1'b0
`define SCSH_PORT_I2C        1'b1

// =====================================================================
// timing
`define SCSH_CLK_HZ          100000000
`define SCSH_RST_MIN_NS      300
`define SCSH_RST_MIN_CYC     ((`SCSH_RST_MIN_NS * (`SCSH_CLK_HZ / 1000000) + 999) / 1000)
`define SCSH_FP_DEF_HZ       8000
`define SCSH_FP_DEF_DIV      (`SCSH_CLK_HZ / `SCSH_FP_DEF_HZ)

`endif

/* hw/scsh_sync2.v */
/*
 * two-flop synchroniser for one level, with reset value.
 * assumes the input is asynchronous to clk; output is the second flop.
 */
`timescale 1ns/10ps
`default_nettype none

module scsh_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire reset,
  input  wire d,
  output reg  q
);

  reg meta_q;

  // =====================================================================
  // meta flop is read only by the second flop
  always @(posedge clk) begin
    if (reset) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* test/scsh_asserts.sv */
/* port checks for scsh_top, one mclk domain.
   bound into every scsh_top below; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module scsh_checker (
  input wire       mclk,
  input wire       reset,
  input wire       i2c_sel_pin,
  input wire       loop_locked,
  input wire       lock_out,
  input wire       loop_holdover,
  input wire       hold_out,
  input wire       irq_pending,
  input wire       status_change,
  input wire       int_oe_n,
  input wire       spi_so_data,
  input wire       serial_out,
  input wire       i2c_sda_low,
  input wire       serial_clk_oe_n,
  input wire       serial_data_oe_n,
  input wire       i2c_enabled,
  input wire       spi_enabled,
  input wire       reg_wr,
  input wire       mode_freerun,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata
);
  // ==========================================
  // port relations
  // the first edge after reset still shows reset values, hence the past(reset) guards
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  lock_out_a: assert property (!$past(reset) |-> lock_out == $past(loop_locked))
    else $error("lock lag wrong");
  hold_out_a: assert property (!$past(reset) |-> hold_out == $past(loop_holdover))
    else $error("hold lag wrong");
  port_sel_a: assert property ($stable(i2c_sel_pin)[*4] ##0 !$past(reset) |->
    i2c_enabled == i2c_sel_pin && spi_enabled != i2c_sel_pin) else $error("port select");
  spi_out_a: assert property ($stable(i2c_sel_pin)[*5] ##0 !$past(reset) |->
    serial_out == (i2c_sel_pin ? 1'b0 : $past(spi_so_data))) else $error("serial out");
  spi_oe_a: assert property ($stable(i2c_sel_pin)[*5] ##0 !i2c_sel_pin |->
    serial_clk_oe_n && serial_data_oe_n) else $error("spi pin driven");
  i2c_oe_a: assert property ($stable(i2c_sel_pin)[*5] ##0 i2c_sel_pin && !$past(reset) |->
    serial_data_oe_n == !$past(i2c_sda_low)) else $error("data drive");
  int_low_a: assert property (irq_pending || status_change |=> !int_oe_n)
    else $error("interrupt not pulled");
  mode_wr_a: assert property (reg_wr && reg_addr == 8'h1F |-> ##2
    mode_freerun == $past(reg_wdata[0], 2)) else $error("mode write lost");
endmodule
bind scsh_top scsh_checker u_chk (.mclk, .reset, .i2c_sel_pin, .loop_locked, .lock_out,
  .loop_holdover, .hold_out, .irq_pending, .status_change, .int_oe_n, .spi_so_data,
  .serial_out, .i2c_sda_low, .serial_clk_oe_n, .serial_data_oe_n, .i2c_enabled,
  .spi_enabled, .reg_wr, .mode_freerun, .reg_addr, .reg_wdata);
`default_nettype wire

/* test/scsh_host_model.sv */
/* host processor on the shared serial pins, spi byte writer.
   clock and select idle high, data starts high; the bench wires them against the device drives. */
`timescale 1ns/10ps
`default_nettype none
module scsh_host_model (
  output logic sck,
  output logic sdi,
  output logic cs_n
);
  initial {sck, sdi, cs_n} = 3'b111;
  // clock stands still outside frames
  task automatic send(input logic [7:0] b);
    #3 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      sck = 1'b0;
      #40 sck = 1'b1;
      #40;
    end
    cs_n = 1'b1;
    // released data must not look held
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
/* bench: scsh_top with the host model and expectations from the pin rules.
   assumes the checker is bound in and the defines header is on the path. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       mclk, reset, mode_pin, i2c, sel, reg_wr, fcw, finv;
  logic [15:0] fdiv, fwid;
  logic [6:0] r;
  logic [7:0] reg_addr, reg_wdata;
  wire        sck, sdi, hcs_n, c_oe_n, d_oe_n, fp, freerun, h_clk, h_dat;
  wire  [7:0] pins;
  int         mismatches, n_tests, cyc;
  integer     k;
  scsh_host_model hm (.sck, .sdi, .cs_n(hcs_n));
  scsh_top #(.FP_DIV(20)) dut (.mclk, .reset, .mode_pin, .i2c_sel_pin(i2c),
    .serial_clk_in(sck & c_oe_n), .serial_clk_oe_n(c_oe_n), .serial_data_in(sdi & d_oe_n),
    .serial_data_oe_n(d_oe_n), .serial_out(pins[4]), .select_or_addr_bit0_pin(sel & hcs_n),
    .int_oe_n(pins[5]), .lock_out(pins[7]), .hold_out(pins[6]), .telecom_frame_pulse_out(fp),
    .loop_locked(r[6]), .loop_holdover(r[5]), .status_change(r[4]), .irq_pending(r[3]),
    .reg_wr, .reg_addr, .reg_wdata, .spi_so_data(r[2]), .i2c_scl_low(r[1]), .i2c_sda_low(r[0]),
    .fp_cfg_wr(fcw), .fp_cfg_div(fdiv), .fp_cfg_width(fwid), .fp_cfg_inv(finv),
    .mode_freerun(freerun), .i2c_enabled(pins[3]), .spi_enabled(pins[2]), .host_clk(h_clk),
    .host_data(h_dat), .spi_cs_n(pins[1]), .i2c_addr_bit0(pins[0]));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [9:0] s, e, input string n);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task do_reset(input logic m);
    mode_pin = m;
    reset = 1'b1;
    tick(30);
    reset = 1'b0;
    tick(2);
    chk(freerun, m, "mode_freerun");
  endtask
  task wr_reg(input logic [7:0] a, d, input logic e);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tick(1);
    reg_wr = 1'b0;
    tick(1);
    chk(freerun, e, "mode_freerun");
  endtask
  // ==========================================
  // host side sampling, 35 ns covers the 3-edge sync path
  always @(sck) if (!hcs_n) begin
    #35;
    chk({h_clk, h_dat, pins[1]}, {sck, sdi, 1'b0}, "host pins");
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      give_verdict;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {reset, mode_pin, i2c, sel, reg_wr, r, reg_addr, reg_wdata} = 28'h8000000;
    {fcw, finv, fdiv, fwid} = 34'h000000014;
    void'($urandom(32'h65CE));
    tick(1);
    do_reset(1'b1);
    wr_reg(8'h1F, 8'h00, 1'b0);
    wr_reg(8'h1E, 8'h01, 1'b0);
    mode_pin = 1'b0;
    tick(6);
    mode_pin = 1'b1;
    tick(3);
    chk(freerun, 1'b0, "mode_freerun");
    tick(1);
    chk(freerun, 1'b1, "mode_freerun");
    wr_reg(8'h1F, 8'hFE, 1'b0);
    $display("mode test over");
    k = 0;
    repeat (200) begin
      tick(1);
      k = k + fp;
    end
    chk(k[9:0], 10'h00A, "frame pulses");
    $display("frame pulse test over");
    // inverted style, period 10, random width 1..9: high 10 - width cycles a period
    fdiv = 16'h000A;
    fwid = 16'(1 + $urandom % 9);
    finv = 1'b1;
    fcw = 1'b1;
    tick(1);
    fcw = 1'b0;
    tick(25);
    k = 0;
    repeat (200) begin
      tick(1);
      k = k + fp;
    end
    chk(k[9:0], 10'(20 * (10 - fwid)), "styled frame pulses");
    $display("frame pulse style test over");
    for (int p = 0; p < 4; p++) begin
      {i2c, sel} = 2'(p);
      tick(6);
      repeat (40) begin
        r = 7'($urandom);
        tick(1);
        chk({pins, c_oe_n, d_oe_n}, {r[6], r[5], !(r[4] | r[3]), !i2c & r[2], i2c, !i2c,
          i2c | sel, i2c & sel, !(i2c & r[1]), !(i2c & r[0])}, "pins");
      end
    end
    $display("pin steering test over");
    {i2c, sel} = 2'b01;
    tick(6);
    hm.send(8'($urandom));
    tick(6);
    do_reset(1'b0);
    $display("spi frame and reset test over");
    give_verdict;
  end
endmodule
`default_nettype wire
